// >>> slas_adapter.sv
// Strobe decode, line registers, sync hunt and status for four lines.
// Assumes receiver/transmitter shifters outside; modem pins are asynchronous.
`timescale 1ns/1ps
module slas_adapter (
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_rst,
    input  wire logic                 i_psel,
    input  wire logic                 i_penable,
    input  wire logic                 i_pwrite,
    input  wire logic [11:0]          i_paddr,
    input  wire logic [31:0]          i_pwdata,
    output logic      [31:0]          o_prdata,
    output logic                      o_pready,
    output logic                      o_pslverr,
    input  wire slas_pkg::slas_mux_t  i_mux,
    output slas_pkg::slas_strobe_t [3:0] o_strobe,
    output logic      [3:0]           o_status_req,
    output logic      [3:0]           o_data_avail,
    output logic      [3:0]           o_parity_err,
    output logic      [3:0]           o_overrun,
    output logic      [3:0][7:0]      o_rx_data,
    input  wire logic [3:0]           i_rx_valid,
    input  wire logic [3:0][7:0]      i_rx_char,
    input  wire logic [3:0]           i_tx_take,
    output logic      [3:0][7:0]      o_tx_char,
    input  wire slas_pkg::slas_modem_t [3:0] i_modem,
    output logic      [3:0]           o_rts,
    output logic      [3:0]           o_dtr,
    output logic      [3:0]           o_ctl_out
);

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    function automatic logic [3:0] kind_dec(input logic [1:0] kind);
        kind_dec = 4'h1 << kind;
    endfunction : kind_dec

    // ---------------------------------------------------------------
    // Storage
    // ---------------------------------------------------------------
    logic [7:0]            ctrl      [4];
    logic [7:0]            tsc       [4];
    logic [7:0]            rsc       [4];
    logic [7:0]            tx_buf    [4];
    logic [3:0]            buf_full;
    logic [3:0]            undr;
    logic [3:0]            cc_seen;
    logic [3:0]            loopback;
    logic [7:0]            data_q;
    slas_pkg::slas_sync_t  sync_st   [4];
    slas_pkg::slas_modem_t [3:0] mdm_meta;
    slas_pkg::slas_modem_t [3:0] mdm;
    slas_pkg::slas_strobe_t [3:0] next_strobe;
    logic [3:0]            sel;
    logic [3:0]            chg;
    logic [3:0]            match;
    logic [3:0]            deliver;
    logic [3:0]            ovr_now;
    logic [3:0]            cts_st;
    logic [3:0]            ilk_st;
    logic [3:0]            car_st;
    logic                  hit;
    logic [3:0]            kinds;

    // ---------------------------------------------------------------
    // Modem pin synchroniser
    // ---------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            mdm_meta <= '0;
            mdm      <= '0;
        end else begin
            mdm_meta <= i_modem;
            mdm      <= mdm_meta;
        end
    end

    // ---------------------------------------------------------------
    // Strobe decode
    // ---------------------------------------------------------------
    assign hit   = i_mux.write && i_mux.enable;
    assign kinds = kind_dec(i_mux.kind) & {4{hit}};

    always_comb begin
        for (int l = 0; l < 4; l++) begin
            sel[l] = i_mux.enable && (i_mux.line == 2'(l));
            chg[l] = mdm[l].control_in ^ cc_seen[l];
            match[l] = (i_rx_char[l] == rsc[l]);
            deliver[l] = i_rx_valid[l] && (sync_st[l] == slas_pkg::SLAS_CHAR)
                         && !(ctrl[l][slas_pkg::CTL_S] && match[l]);
            ovr_now[l] = deliver[l] && o_data_avail[l];
            next_strobe[l].tx_data_load_strobe      = sel[l] && kinds[0];
            next_strobe[l].control_reg_load_strobe  = sel[l] && kinds[1];
            next_strobe[l].tx_sync_char_load_strobe = sel[l] && kinds[2];
            next_strobe[l].rx_sync_char_load_strobe = sel[l] && kinds[3];
            next_strobe[l].edge_detector_clear_strobe =
                (sel[l] && hit && !ctrl[l][slas_pkg::CTL_T] && !ctrl[l][slas_pkg::CTL_R])
                || (sel[l] && i_mux.stat_cycle && chg[l]);
            next_strobe[l].data_avail_clear_strobe =
                sel[l] && i_mux.data_cycle && !ovr_now[l];
        end
    end

    // Registered so every strobe is glitch free
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_strobe <= '0;
            data_q   <= 8'h00;
        end else begin
            o_strobe <= next_strobe;
            data_q   <= i_mux.data;
        end
    end

    // ---------------------------------------------------------------
    // Line registers and transmit side
    // ---------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int l = 0; l < 4; l++) begin
                ctrl[l]   <= slas_pkg::CTL_RESET;
                tsc[l]    <= slas_pkg::SYNC_RESET;
                rsc[l]    <= slas_pkg::SYNC_RESET;
                tx_buf[l] <= 8'h00;
            end
            buf_full  <= 4'h0;
            undr      <= 4'h0;
            o_tx_char <= '0;
        end else begin
            for (int l = 0; l < 4; l++) begin
                if (o_strobe[l].control_reg_load_strobe)
                    ctrl[l] <= data_q;
                if (o_strobe[l].tx_sync_char_load_strobe)
                    tsc[l] <= data_q;
                if (o_strobe[l].rx_sync_char_load_strobe)
                    rsc[l] <= data_q;
                if (i_tx_take[l]) begin
                    if (buf_full[l] && !ctrl[l][slas_pkg::CTL_A]) begin
                        o_tx_char[l] <= tx_buf[l];
                        buf_full[l]  <= 1'b0;
                        undr[l]      <= 1'b0;
                    end else begin
                        o_tx_char[l] <= tsc[l];
                        undr[l]      <= ctrl[l][slas_pkg::CTL_T];
                    end
                end
                // Fresh data wins over a take in the same cycle
                if (o_strobe[l].tx_data_load_strobe) begin
                    tx_buf[l]   <= data_q;
                    buf_full[l] <= 1'b1;
                    undr[l]     <= 1'b0;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Control-channel edge detectors
    // ---------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            cc_seen <= 4'h0;
        end else begin
            for (int l = 0; l < 4; l++) begin
                if (o_strobe[l].edge_detector_clear_strobe)
                    cc_seen[l] <= mdm[l].control_in;
            end
        end
    end

    // ---------------------------------------------------------------
    // Sync hunt and receive flags
    // ---------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int l = 0; l < 4; l++)
                sync_st[l] <= slas_pkg::SLAS_HUNT;
        end else begin
            for (int l = 0; l < 4; l++) begin
                if (o_strobe[l].rx_sync_char_load_strobe || !ctrl[l][slas_pkg::CTL_R]) begin
                    sync_st[l] <= slas_pkg::SLAS_HUNT;
                end else if (i_rx_valid[l]) begin
                    unique case (sync_st[l])
                        slas_pkg::SLAS_HUNT: if (match[l]) sync_st[l] <= slas_pkg::SLAS_ONE;
                        slas_pkg::SLAS_ONE:  sync_st[l] <= match[l] ? slas_pkg::SLAS_CHAR
                                                                    : slas_pkg::SLAS_HUNT;
                        slas_pkg::SLAS_CHAR: sync_st[l] <= slas_pkg::SLAS_CHAR;
                        default:             sync_st[l] <= slas_pkg::SLAS_HUNT;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_data_avail <= 4'h0;
            o_parity_err <= 4'h0;
            o_overrun    <= 4'h0;
            o_rx_data    <= '0;
        end else begin
            for (int l = 0; l < 4; l++) begin
                if (deliver[l]) begin
                    o_data_avail[l] <= 1'b1; // Set wins over clear
                    o_overrun[l]    <= ovr_now[l];
                    o_parity_err[l] <= ctrl[l][slas_pkg::CTL_P] && !(^i_rx_char[l]);
                    o_rx_data[l]    <= ctrl[l][slas_pkg::CTL_P] ? {1'b0, i_rx_char[l][6:0]}
                                                                : i_rx_char[l];
                end else if (o_strobe[l].data_avail_clear_strobe) begin
                    o_data_avail[l] <= 1'b0;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Modem outputs and status
    // ---------------------------------------------------------------
    always_comb begin
        for (int l = 0; l < 4; l++) begin
            cts_st[l] = loopback[l] ? ctrl[l][slas_pkg::CTL_T] : mdm[l].cts;
            ilk_st[l] = loopback[l] ? ctrl[l][slas_pkg::CTL_D] : mdm[l].interlock;
            car_st[l] = loopback[l] ? ctrl[l][slas_pkg::CTL_D] : mdm[l].carrier;
            o_status_req[l] = chg[l] || mdm[l].ring || undr[l];
            o_rts[l]     = ctrl[l][slas_pkg::CTL_T];
            o_dtr[l]     = ctrl[l][slas_pkg::CTL_D];
            o_ctl_out[l] = ctrl[l][slas_pkg::CTL_C];
        end
    end

    // ---------------------------------------------------------------
    // APB slave, zero wait states
    // ---------------------------------------------------------------
    function automatic logic [31:0] stat_word(input int l);
        stat_word = {19'h0, o_status_req[l], sync_st[l] == slas_pkg::SLAS_CHAR,
                     o_overrun[l], o_parity_err[l], o_data_avail[l],
                     ilk_st[l], car_st[l], cts_st[l], 2'h0,
                     mdm[l].ring, mdm[l].control_in, undr[l]};
    endfunction : stat_word

    logic [1:0] pidx;
    assign pidx     = i_paddr[3:2];
    assign o_pready = 1'b1;

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
            loopback  <= slas_pkg::CFG_RESET;
        end else begin
            if (i_psel && !i_penable) begin
                o_prdata  <= 32'h0000_0000;
                o_pslverr <= 1'b0;
                if (i_paddr == slas_pkg::ADDR_CFG)
                    o_prdata <= {28'h0, loopback};
                else if ({i_paddr[11:4], 4'h0} == slas_pkg::ADDR_STAT_BASE && i_paddr[1:0] == 2'h0)
                    o_prdata <= stat_word(int'(pidx));
                else if ({i_paddr[11:4], 4'h0} == slas_pkg::ADDR_CTL_BASE && i_paddr[1:0] == 2'h0)
                    o_prdata <= {8'h0, rsc[pidx], tsc[pidx], ctrl[pidx]};
                else
                    o_pslverr <= 1'b1;
            end
            if (i_psel && i_penable && i_pwrite && i_paddr == slas_pkg::ADDR_CFG)
                loopback <= i_pwdata[3:0];
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    logic [15:0] load_bits;
    always_comb begin
        for (int l = 0; l < 4; l++)
            load_bits[4*l +: 4] = {o_strobe[l].tx_data_load_strobe, o_strobe[l].control_reg_load_strobe,
                                   o_strobe[l].tx_sync_char_load_strobe, o_strobe[l].rx_sync_char_load_strobe};
    end

    sequence s_ctl_write_line0;
        hit && i_mux.kind == slas_pkg::KIND_CONTROL && i_mux.line == 2'h0;
    endsequence
    sequence s_idle_strobe_line1;
        hit && i_mux.line == 2'h1 && !ctrl[1][slas_pkg::CTL_T] && !ctrl[1][slas_pkg::CTL_R];
    endsequence

    a_load_needs_write: assert property (|load_bits |-> $past(hit))
        else $error("load strobe without write");
    a_type_decode: assert property (hit && i_mux.kind == slas_pkg::KIND_TX_SYNC && i_mux.line == 2'h2
                                    |=> o_strobe[2].tx_sync_char_load_strobe)
        else $error("sync load strobe missing");
    a_one_line: assert property ($onehot0(load_bits))
        else $error("strobe on more than one line");
    a_idle_clear: assert property (s_idle_strobe_line1 |=> o_strobe[1].edge_detector_clear_strobe)
        else $error("idle line missed edge clear");
    a_rds_suppress: assert property (i_mux.data_cycle && sel[1] && ovr_now[1]
                                     |=> !o_strobe[1].data_avail_clear_strobe)
        else $error("clear not suppressed on overrun");
    a_dtr_follow: assert property (s_ctl_write_line0 ##0 i_mux.data[slas_pkg::CTL_D]
                                   |-> ##2 o_dtr[0])
        else $error("dtr did not follow control");
    a_cts_loop: assert property (loopback[0] && o_strobe[0].control_reg_load_strobe
                                 |=> cts_st[0] == $past(data_q[slas_pkg::CTL_T]))
        else $error("looped cts wrong");
    a_two_sync: assert property (sync_st[1] == slas_pkg::SLAS_CHAR
                                 && $past(sync_st[1]) != slas_pkg::SLAS_CHAR
                                 |-> $past(sync_st[1]) == slas_pkg::SLAS_ONE)
        else $error("character mode without two syncs");
    a_resync_drop: assert property (o_strobe[1].rx_sync_char_load_strobe |=> sync_st[1] == slas_pkg::SLAS_HUNT)
        else $error("sync not dropped");
    a_dav_clear: assert property (o_strobe[1].data_avail_clear_strobe && !deliver[1]
                                  |=> !o_data_avail[1])
        else $error("data available not cleared");

    // ---------------------------------------------------------------
    // Flags, transmit and receive paths
    // ---------------------------------------------------------------
    a_strobe_addressed: assert property (|o_strobe |-> $past(i_mux.enable))
        else $error("strobe without bus cycle");

    a_stat_clear: assert property (i_mux.stat_cycle && sel[0] && chg[0]
        |=> o_strobe[0].edge_detector_clear_strobe)
        else $error("reported change not cleared");

    a_stat_quiet: assert property (i_mux.stat_cycle && !hit && sel[0] && !chg[0]
        |=> !o_strobe[0].edge_detector_clear_strobe)
        else $error("edge clear without change");

    a_edge_update: assert property (o_strobe[0].edge_detector_clear_strobe
        |=> cc_seen[0] == $past(mdm[0].control_in))
        else $error("edge detector not updated");

    a_rds_issue: assert property (i_mux.data_cycle && sel[1] && !ovr_now[1]
        |=> o_strobe[1].data_avail_clear_strobe)
        else $error("data request without clear");

    a_underflow_req: assert property (i_tx_take[0] && !buf_full[0] && ctrl[0][slas_pkg::CTL_T]
        && !o_strobe[0].tx_data_load_strobe |=> o_status_req[0])
        else $error("underflow without status request");

    a_sync_sent: assert property (i_tx_take[0] && !buf_full[0] |=> o_tx_char[0] == $past(tsc[0]))
        else $error("sync character not sent");

    a_parity_flag: assert property (deliver[1] && ctrl[1][slas_pkg::CTL_P]
        |=> o_parity_err[1] == !(^$past(i_rx_char[1])))
        else $error("parity flag wrong");

    a_overrun_flag: assert property (deliver[1] && o_data_avail[1] |=> o_overrun[1])
        else $error("overrun not reported");

    a_seven_bit: assert property (deliver[1] && ctrl[1][slas_pkg::CTL_P] |=> !o_rx_data[1][7])
        else $error("parity bit passed as data");

    a_hunt_match: assert property (sync_st[1] == slas_pkg::SLAS_HUNT && i_rx_valid[1] && match[1]
        && ctrl[1][slas_pkg::CTL_R] && !o_strobe[1].rx_sync_char_load_strobe
        |=> sync_st[1] == slas_pkg::SLAS_ONE)
        else $error("sync character missed in hunt");

    a_no_early_data: assert property (sync_st[1] != slas_pkg::SLAS_CHAR
        |=> !$rose(o_data_avail[1]))
        else $error("data before character mode");

    a_rts_follow: assert property (s_ctl_write_line0 ##0 i_mux.data[slas_pkg::CTL_T]
        |-> ##2 o_rts[0])
        else $error("rts did not follow control");

    a_ctl_out: assert property (s_ctl_write_line0 ##0 !i_mux.data[slas_pkg::CTL_C]
        |-> ##2 !o_ctl_out[0])
        else $error("control output not cleared");

    a_resync_load: assert property (o_strobe[1].rx_sync_char_load_strobe
        |=> rsc[1] == $past(data_q))
        else $error("receive sync not loaded");

endmodule : slas_adapter

// >>> slas_adapter_test.sv
// Self-checking bench for the line adapter strobe logic.
// Assumes the multiplexor model file and the design package are compiled first.
`timescale 1ns/1ps
module slas_adapter_test;
    logic                          clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0]                   paddr;
    logic [31:0]                   pwdata, prdata;
    slas_pkg::slas_mux_t           mux;
    slas_pkg::slas_strobe_t [3:0]  stb;
    slas_pkg::slas_modem_t  [3:0]  modem;
    logic [3:0]                    sreq, dav, pe, ovr, rts, dtr, cout, rxv, take;
    logic [3:0][7:0]               rxd, rxc, txc;
    int                            err_count, cmp_count, cyc;
    logic [23:0]                   sq[$];
    logic [65:0]                   rq[$];

    slas_mux_model mdl (.i_sys_clk(clk), .o_mux(mux));
    slas_adapter dut (.i_sys_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_mux(mux), .o_strobe(stb),
        .o_status_req(sreq), .o_data_avail(dav), .o_parity_err(pe), .o_overrun(ovr),
        .o_rx_data(rxd), .i_rx_valid(rxv), .i_rx_char(rxc), .i_tx_take(take),
        .o_tx_char(txc), .i_modem(modem), .o_rts(rts), .o_dtr(dtr), .o_ctl_out(cout));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic cmp(input logic [32:0] g, input logic [32:0] e);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : cmp

    task automatic complete_run;
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    function automatic logic [23:0] sv(input int l, input logic [5:0] b);
        sv = 24'h0;
        sv[l*6 +: 6] = b;
    endfunction : sv

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       input logic [32:0] m, input logic [32:0] e);
        if (!w) rq.push_back({m, e});
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Receiver or transmitter pulse; result settles one edge after the take
    task automatic pulse(input logic [3:0] tk, input logic [3:0] rv, input int l, input logic [7:0] ch);
        @(posedge clk);
        take <= tk; rxv <= rv; rxc[l] <= ch;
        @(posedge clk);
        take <= 4'h0; rxv <= 4'h0; rxc[l] <= ~ch;
        repeat (2) @(negedge clk);
    endtask : pulse

    // ---------------------------------------------------------------
    // Watchers: oldest note against each result as it appears
    // ---------------------------------------------------------------
    always @(negedge clk) begin : watch
        logic [65:0] n;
        if (!rst && stb !== 24'h0) cmp(stb, sq.size() ? sq.pop_front() : 24'h0);
        if (psel && penable && pready && !pwrite && rq.size()) begin
            n = rq.pop_front();
            cmp({pslverr, prdata} & n[65:33], n[32:0]);
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            complete_run();
        end
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        logic [7:0] d, c, t, r, x, y;
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
        modem = '0; rxv = 4'h0; rxc = '0; take = 4'h0;
        err_count = 0; cmp_count = 0; cyc = 0; c = 8'h00;
        void'($urandom(21514));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        cmp(stb, 0);
        for (int k = 0; k < 4; k++) begin
            d = 8'($urandom) & 8'h3F;
            if (k == 1) c = d;
            sq.push_back(sv(2, (6'h20 >> k) | 6'h02));
            mdl.issue(1'b1, 1'b1, 2'(k), 2'h2, d, 1'b0, 1'b0);
        end
        mdl.issue(1'b0, 1'b1, 2'h1, 2'h2, 8'hFF, 1'b0, 1'b0);
        mdl.issue(1'b1, 1'b0, 2'h1, 2'h2, 8'hFF, 1'b0, 1'b0);
        repeat (2) @(negedge clk);
        cmp({rts[2], dtr[2], cout[2]}, {c[7], c[4], c[2]});
        $display("test decode done");
        sq.push_back(sv(0, 6'h12));
        mdl.issue(1'b1, 1'b1, 2'h1, 2'h0, 8'h80, 1'b0, 1'b0);
        apb(1'b1, 12'h000, 32'h9, 33'h0, 33'h0);
        repeat (4) @(posedge clk);
        apb(1'b0, 12'h010, 32'h0, 33'hE0, 33'h20);
        apb(1'b0, 12'h01C, 32'h0, 33'hE0, 33'h00);
        sq.push_back(sv(0, 6'h10));
        mdl.issue(1'b1, 1'b1, 2'h1, 2'h0, 8'h90, 1'b0, 1'b0);
        repeat (4) @(posedge clk);
        apb(1'b0, 12'h010, 32'h0, 33'hE0, 33'hE0);
        apb(1'b0, 12'h100, 32'h0, '1, 33'h1_0000_0000);
        $display("test modem done");
        mdl.issue(1'b0, 1'b1, 2'h0, 2'h0, 8'h00, 1'b1, 1'b0);
        @(posedge clk);
        modem[0].control_in <= 1'b1;
        repeat (4) @(negedge clk);
        cmp(sreq[0], 1);
        sq.push_back(sv(0, 6'h02));
        mdl.issue(1'b0, 1'b1, 2'h0, 2'h0, 8'h00, 1'b1, 1'b0);
        repeat (3) @(negedge clk);
        cmp(sreq[0], 0);
        t = 8'($urandom);
        sq.push_back(sv(0, 6'h08));
        mdl.issue(1'b1, 1'b1, 2'h2, 2'h0, t, 1'b0, 1'b0);
        pulse(4'h1, 4'h0, 0, 8'h00);
        cmp({sreq[0], txc[0]}, {1'b1, t});
        d = 8'($urandom);
        sq.push_back(sv(0, 6'h20));
        mdl.issue(1'b1, 1'b1, 2'h0, 2'h0, d, 1'b0, 1'b0);
        pulse(4'h1, 4'h0, 0, 8'h00);
        cmp({sreq[0], txc[0]}, {1'b0, d});
        $display("test transmit done");
        sq.push_back(sv(1, 6'h12));
        mdl.issue(1'b1, 1'b1, 2'h1, 2'h1, 8'h60, 1'b0, 1'b0);
        r = 8'($urandom);
        sq.push_back(sv(1, 6'h04));
        mdl.issue(1'b1, 1'b1, 2'h3, 2'h1, r, 1'b0, 1'b0);
        pulse(4'h0, 4'h2, 1, r);
        pulse(4'h0, 4'h2, 1, r);
        cmp(dav[1], 0);
        x = 8'($urandom);
        pulse(4'h0, 4'h2, 1, x);
        cmp({dav[1], pe[1], rxd[1]}, {1'b1, ~^x, 1'b0, x[6:0]});
        y = 8'($urandom);
        fork
            mdl.issue(1'b0, 1'b1, 2'h0, 2'h1, 8'h00, 1'b0, 1'b1);
            pulse(4'h0, 4'h2, 1, y);
        join
        cmp(ovr[1], 1);
        sq.push_back(sv(1, 6'h01));
        mdl.issue(1'b0, 1'b1, 2'h0, 2'h1, 8'h00, 1'b0, 1'b1);
        repeat (2) @(negedge clk);
        cmp(dav[1], 0);
        apb(1'b0, 12'h014, 32'h0, 33'h800, 33'h800);
        sq.push_back(sv(1, 6'h04));
        mdl.issue(1'b1, 1'b1, 2'h3, 2'h1, ~r, 1'b0, 1'b0);
        repeat (3) @(posedge clk);
        apb(1'b0, 12'h014, 32'h0, 33'h800, 33'h000);
        $display("test receive done");
        repeat (4) @(negedge clk);
        cmp(sq.size(), 0);
        complete_run();
    end
endmodule : slas_adapter_test

// >>> slas_mux_model.sv
// Multiplexor unit model: issues bus cycles toward the line adapter.
// Assumes the adapter's clock; cycles start only after reset is released.
`timescale 1ns/1ps
module slas_mux_model (
    input  wire logic           i_sys_clk,
    output slas_pkg::slas_mux_t o_mux
);
    initial o_mux = '0;

    // ---------------------------------------------------------------
    // One bus cycle, held for exactly one sampling edge
    // ---------------------------------------------------------------
    task automatic issue(input logic w, input logic en, input logic [1:0] k, input logic [1:0] l,
                         input logic [7:0] d, input logic st, input logic dc);
        @(posedge i_sys_clk);
        o_mux <= {w, en, k, l, d, st, dc};
        @(posedge i_sys_clk);
        // Released lines show the inverse, so a stale byte never looks valid
        o_mux <= {2'b00, ~k, ~l, ~d, 2'b00};
    endtask : issue
endmodule : slas_mux_model

// >>> slas_pkg.sv
// Constants and carrier types for the four-line sync line adapter strobe logic.
// Assumes one 100 MHz clock; multiplexor bus signals come from logic on that clock.
package slas_pkg;

    localparam int NLINES = 4;

    // ---------------------------------------------------------------
    // Byte type codes on the multiplexor bus
    // ---------------------------------------------------------------
    localparam logic [1:0] KIND_TX_DATA = 2'h0;
    localparam logic [1:0] KIND_CONTROL = 2'h1;
    localparam logic [1:0] KIND_TX_SYNC = 2'h2;
    localparam logic [1:0] KIND_RX_SYNC = 2'h3;

    // ---------------------------------------------------------------
    // Line control byte fields
    // ---------------------------------------------------------------
    localparam int CTL_T = 7;
    localparam int CTL_R = 6;
    localparam int CTL_P = 5;
    localparam int CTL_D = 4;
    localparam int CTL_A = 3;
    localparam int CTL_C = 2;
    localparam int CTL_I = 1;
    localparam int CTL_S = 0;
    localparam logic [7:0] CTL_RESET  = 8'h00;
    localparam logic [7:0] SYNC_RESET = 8'h00;

    // ---------------------------------------------------------------
    // APB map
    // ---------------------------------------------------------------
    localparam logic [11:0] ADDR_CFG       = 12'h000;
    localparam logic [11:0] ADDR_STAT_BASE = 12'h010;
    localparam logic [11:0] ADDR_CTL_BASE  = 12'h020;
    localparam logic [3:0]  CFG_RESET      = 4'h0;
    localparam int ST_DAV  = 8;
    localparam int ST_PE   = 9;
    localparam int ST_OVR  = 10;
    localparam int ST_SYNC = 11;
    localparam int ST_REQ  = 12;

    typedef enum logic [1:0] {
        SLAS_HUNT = 2'h0,
        SLAS_ONE  = 2'h1,
        SLAS_CHAR = 2'h3
    } slas_sync_t;

    typedef struct packed {
        logic       write;
        logic       enable;
        logic [1:0] kind;
        logic [1:0] line;
        logic [7:0] data;
        logic       stat_cycle;
        logic       data_cycle;
    } slas_mux_t;

    typedef struct packed {
        logic tx_data_load_strobe;
        logic control_reg_load_strobe;
        logic tx_sync_char_load_strobe;
        logic rx_sync_char_load_strobe;
        logic edge_detector_clear_strobe;
        logic data_avail_clear_strobe;
    } slas_strobe_t;

    typedef struct packed {
        logic cts;
        logic interlock;
        logic carrier;
        logic ring;
        logic control_in;
    } slas_modem_t;

endpackage : slas_pkg
